// *** src/sdq_pkg.sv ***
// Purpose: shared constants and types of the card transfer sequencer
// Assumes: 40 MHz controller clock
// Notes: card command indices follow the public card command set
package sdq_pkg;
  // clock and idle timeout
  localparam int unsigned CLK_PERIOD_NS = 25;
  localparam int unsigned HOLD_TMO_NS = 1_000_000;
  localparam int unsigned HOLD_TMO_CYC = HOLD_TMO_NS / CLK_PERIOD_NS;
  // addressing
  localparam logic [2:0] OPT_LBA = 3'h4;
  localparam int unsigned BLK_SHIFT = 9;
  // card command indices
  localparam logic [5:0] CIDX_STOP = 6'h0C;
  localparam logic [5:0] CIDX_APP = 6'h37;
  localparam logic [5:0] CIDX_PRE_ERASE = 6'h17;
  localparam logic [5:0] CIDX_RD_MULTI = 6'h12;
  localparam logic [5:0] CIDX_WR_MULTI = 6'h19;
  localparam logic [5:0] CIDX_RD_STREAM = 6'h0B;
  localparam logic [5:0] CIDX_WR_STREAM = 6'h14;
  // register offsets and fields
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_RCA = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;
  localparam logic [7:0] REG_LENGTH = 8'h0C;
  localparam int unsigned CTRL_HOLD_RD = 0;
  localparam int unsigned CTRL_HOLD_WR = 1;
  localparam int unsigned CTRL_STREAM = 2;
  localparam int unsigned CTRL_CONTIN = 3;
  localparam int unsigned CTRL_LARGE = 4;
  localparam int unsigned STAT_ERR = 8;
  localparam logic [10:0] CTRL_RST = 11'h000;
  localparam logic [15:0] RCA_RST = 16'h0000;

  // commands from the data unit
  typedef enum logic [2:0] {
    DC_NEW_READ = 3'b000,
    DC_CONT_READ = 3'b001,
    DC_NEW_WRITE = 3'b010,
    DC_CONT_WRITE = 3'b011,
    DC_MAN_READ = 3'b100,
    DC_MAN_WRITE = 3'b101
  } sdq_dcmd_e;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0000,
    ST_CWAIT = 4'b0001,
    ST_DATA = 4'b0010,
    ST_HOLD = 4'b0011
  } sdq_st_e;

  // what follows a completed card command
  typedef enum logic [2:0] {
    AFT_IDLE = 3'b000,
    AFT_PEND = 3'b001,
    AFT_ERASE = 3'b010,
    AFT_WR = 3'b011,
    AFT_DATA = 3'b100
  } sdq_aft_e;

  typedef struct packed {
    logic [31:0] start_addr;
    logic [15:0] xfer_length;
    logic [2:0] block_size;
    sdq_dcmd_e cmd;
    logic [1:0] dev_sel;
    logic [3:0] dev_id;
  } sdq_dcmd_s;

  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } sdq_bus_s;

  typedef struct packed {
    logic req;
    logic [5:0] index;
    logic [31:0] arg;
  } sdq_ccmd_s;
endpackage

// *** src/sdq_sequencer.sv ***
// Purpose: sequencer turning data unit commands into card command runs
// Assumes: card command engine and DMA on the same clock
// Notes: length counter always counts bytes; stream ignores it
//
// Added by the designer: the strobed register port and the address map.
`timescale 1ns/100ps
`default_nettype none

module sdq_sequencer
  import sdq_pkg::*;
#(
  parameter int unsigned TMO_CYC = HOLD_TMO_CYC,
  parameter logic [1:0] UNIT_SEL = 2'h0
) (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  // register port
  input wire sdq_bus_s bus_i,
  output logic [31:0] bus_rdata_o,
  // data unit command port
  input wire logic dcmd_valid_i,
  input wire sdq_dcmd_s dcmd_i,
  output logic dcmd_ack_o,
  output logic dcmd_ready_o,
  output logic dcmd_err_o,
  // card command engine via response buffer
  output sdq_ccmd_s ccmd_o,
  input wire logic ccmd_done_i,
  input wire logic ccmd_err_i,
  // data phase
  output logic dma_start_o,
  input wire logic dma_byte_i,
  input wire logic dma_done_i,
  output logic clk_freeze_o,
  output logic busy_o
);

  typedef struct packed {
    sdq_st_e st;
    sdq_aft_e aft;
    logic [24:0] len;
    logic [31:0] addr;
    logic wr;
    logic manual;
    logic newwr;
    logic strm;
    logic open;
    logic freeze;
    logic [15:0] tmo;
    logic ack;
    logic rdy;
    logic dma;
    logic err;
    sdq_ccmd_s ccmd;
    logic [10:0] ctrl;
    logic [15:0] rca;
    logic errflag;
    logic [31:0] rdata;
    logic busy;
  } sdq_state_s;

  sdq_state_s q_ff;
  sdq_state_s nxt_q;

  // issue one card command through the response buffer
  function automatic sdq_state_s launch(input sdq_state_s s, input logic [5:0] idx,
                                        input logic [31:0] arg, input sdq_aft_e aft);
    sdq_state_s r;
    r = s;
    r.ccmd.req = 1'b1;
    r.ccmd.index = idx;
    r.ccmd.arg = arg;
    r.aft = aft;
    r.st = ST_CWAIT;
    return r;
  endfunction

  // first card command of a fresh transfer
  function automatic sdq_state_s start_xfer(input sdq_state_s s);
    sdq_state_s r;
    r = s;
    if (s.wr) begin
      // application command carries the card address
      r = launch(s, CIDX_APP, {s.rca, 16'h0000},
                 s.ctrl[CTRL_HOLD_WR] ? AFT_WR : AFT_ERASE);
    end else begin
      r = launch(s, s.strm ? CIDX_RD_STREAM : CIDX_RD_MULTI, s.addr, AFT_DATA);
    end
    return r;
  endfunction

  // take a command from the data unit
  function automatic sdq_state_s dispatch(input sdq_state_s s, input sdq_dcmd_s c);
    sdq_state_s r;
    logic lba;
    logic cwr;
    r = s;
    lba = (s.ctrl[10:8] == OPT_LBA) || s.ctrl[CTRL_LARGE];
    cwr = (c.cmd == DC_NEW_WRITE) || (c.cmd == DC_CONT_WRITE) || (c.cmd == DC_MAN_WRITE);
    r.ack = 1'b1;
    r.tmo = 16'h0000;
    r.freeze = 1'b0;
    r.wr = cwr;
    r.strm = s.ctrl[CTRL_STREAM];
    r.manual = 1'b0;
    r.newwr = 1'b0;
    if ((c.cmd == DC_MAN_READ) || (c.cmd == DC_MAN_WRITE)) begin
      // manual: length as given, straight to data
      r.len = {9'h000, c.xfer_length};
      r.manual = 1'b1;
      r.dma = 1'b1;
      r.open = 1'b1;
      r.st = ST_DATA;
    end else begin
      r.len = {c.xfer_length, 9'h000};
      if (((c.cmd == DC_CONT_READ) || (c.cmd == DC_CONT_WRITE)) && s.open &&
          (s.wr == cwr) && !s.manual && !s.strm) begin
        // continuation: skip card commands, data unit starts the DMA
        r.rdy = 1'b1;
        r.st = ST_DATA;
      end else begin
        r.addr = lba ? c.start_addr : {c.start_addr[22:0], 9'h000};
        r.newwr = (c.cmd == DC_NEW_WRITE);
        if (s.open) begin
          r = launch(r, CIDX_STOP, 32'h0000_0000, AFT_PEND);
        end else begin
          r = start_xfer(r);
        end
      end
    end
    return r;
  endfunction

  // read data for the register port
  function automatic logic [31:0] reg_read(input sdq_state_s s, input logic [7:0] a);
    logic [31:0] d;
    d = 32'h0000_0000;
    case (a)
      REG_CTRL: d = {21'h000000, s.ctrl};
      REG_RCA: d = {16'h0000, s.rca};
      REG_STATUS: d = {23'h000000, s.errflag, 2'b00, s.open, s.freeze, s.st};
      REG_LENGTH: d = {7'h00, s.len};
      default: d = 32'h0000_0000;
    endcase
    return d;
  endfunction

  logic cmd_here;
  assign cmd_here = dcmd_valid_i && (dcmd_i.dev_sel == UNIT_SEL) && !q_ff.ack;

  // next state
  always_comb begin
    nxt_q = q_ff;
    nxt_q.ack = 1'b0;
    nxt_q.rdy = 1'b0;
    nxt_q.dma = 1'b0;
    nxt_q.err = 1'b0;
    nxt_q.ccmd.req = 1'b0;
    nxt_q.rdata = 32'h0000_0000;
    // register port
    if (bus_i.rd) begin
      nxt_q.rdata = reg_read(q_ff, bus_i.addr);
    end
    if (bus_i.wr) begin
      case (bus_i.addr)
        REG_CTRL: nxt_q.ctrl = bus_i.wdata[10:0];
        REG_RCA: nxt_q.rca = bus_i.wdata[15:0];
        REG_STATUS: begin
          if (bus_i.wdata[STAT_ERR]) begin
            nxt_q.errflag = 1'b0;
          end
        end
        default: nxt_q.ctrl = q_ff.ctrl;
      endcase
    end
    case (q_ff.st)
      ST_IDLE: begin
        nxt_q.open = 1'b0;
        if (cmd_here) begin
          nxt_q = dispatch(nxt_q, dcmd_i);
        end
      end
      ST_CWAIT: begin
        if (ccmd_done_i) begin
          if (ccmd_err_i) begin
            // response error: no data phase
            nxt_q.err = 1'b1;
            nxt_q.errflag = 1'b1;
            nxt_q.open = 1'b0;
            nxt_q.st = ST_IDLE;
          end else begin
            case (q_ff.aft)
              AFT_IDLE: begin
                nxt_q.open = 1'b0;
                nxt_q.st = ST_IDLE;
              end
              AFT_PEND: begin
                nxt_q.open = 1'b0;
                nxt_q = start_xfer(nxt_q);
              end
              AFT_ERASE: begin
                nxt_q = launch(nxt_q, CIDX_PRE_ERASE, {16'h0000, q_ff.len[24:9]},
                               AFT_WR);
              end
              AFT_WR: begin
                nxt_q = launch(nxt_q, q_ff.strm ? CIDX_WR_STREAM : CIDX_WR_MULTI,
                               q_ff.addr, AFT_DATA);
              end
              AFT_DATA: begin
                nxt_q.dma = 1'b1;
                nxt_q.open = 1'b1;
                nxt_q.st = ST_DATA;
              end
              default: nxt_q.st = ST_IDLE;
            endcase
          end
        end
      end
      ST_DATA: begin
        // byte accounting and clock freeze
        if (dma_byte_i && !q_ff.strm && !q_ff.freeze) begin
          nxt_q.len = q_ff.len - 25'h0000001;
          nxt_q.freeze = (q_ff.len == 25'h0000001);
          if (q_ff.newwr) begin
            nxt_q.addr = q_ff.addr + 32'h0000_0001;
          end
        end
        if (q_ff.strm && q_ff.ctrl[CTRL_CONTIN]) begin
          // continuous stream ends only on a new command
          if (cmd_here) begin
            nxt_q = dispatch(nxt_q, dcmd_i);
          end
        end else if (dma_done_i) begin
          if (q_ff.manual) begin
            nxt_q.st = ST_IDLE;
          end else if (!q_ff.strm &&
                       (q_ff.wr ? q_ff.ctrl[CTRL_HOLD_WR] : q_ff.ctrl[CTRL_HOLD_RD])) begin
            nxt_q.tmo = 16'h0000;
            nxt_q.st = ST_HOLD;
          end else begin
            nxt_q = launch(nxt_q, CIDX_STOP, 32'h0000_0000, AFT_IDLE);
          end
        end
      end
      ST_HOLD: begin
        if (cmd_here) begin
          nxt_q = dispatch(nxt_q, dcmd_i);
        end else if (32'(q_ff.tmo) >= TMO_CYC - 1) begin
          nxt_q = launch(nxt_q, CIDX_STOP, 32'h0000_0000, AFT_IDLE);
        end else begin
          nxt_q.tmo = q_ff.tmo + 16'h0001;
        end
      end
      default: nxt_q.st = ST_IDLE;
    endcase
    // a new error wins over a software clear in the same cycle
    if (nxt_q.err) begin
      nxt_q.errflag = 1'b1;
    end
    // busy kept as a flop so the port needs no decode
    nxt_q.busy = (nxt_q.st != ST_IDLE);
  end

  // state register
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      q_ff <= '0;
      q_ff.st <= ST_IDLE;
      q_ff.aft <= AFT_IDLE;
      q_ff.ctrl <= CTRL_RST;
      q_ff.rca <= RCA_RST;
    end else begin
      q_ff <= nxt_q;
    end
  end

  // outputs straight from the state register
  assign bus_rdata_o = q_ff.rdata;
  assign dcmd_ack_o = q_ff.ack;
  assign dcmd_ready_o = q_ff.rdy;
  assign dcmd_err_o = q_ff.err;
  assign ccmd_o = q_ff.ccmd;
  assign dma_start_o = q_ff.dma;
  assign clk_freeze_o = q_ff.freeze;
  assign busy_o = q_ff.busy;

endmodule
`default_nettype wire

// *** test/sdq_sequencer_asserts.sv ***
// Purpose: port checks of the transfer sequencer
// Assumes: one clock, async high reset
// Notes: bound into every sequencer
`timescale 1ns/100ps
`default_nettype none
module sdq_sequencer_asserts
  import sdq_pkg::*;
(
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  // watched ports
  input wire sdq_bus_s bus_i,
  input wire logic [31:0] bus_rdata_o,
  input wire logic dcmd_valid_i,
  input wire logic dcmd_ack_o,
  input wire logic dcmd_ready_o,
  input wire logic dcmd_err_o,
  input wire sdq_ccmd_s ccmd_o,
  input wire logic ccmd_done_i,
  input wire logic ccmd_err_i,
  input wire logic dma_start_o,
  input wire logic clk_freeze_o,
  input wire logic busy_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (sys_rst_i);
  // handshake, bus, card command, DMA and clock freeze checks
  ack_has_valid_a: assert property (dcmd_ack_o |-> $past(dcmd_valid_i))
    else $error("ack without valid");
  ack_busy_a: assert property (dcmd_ack_o |-> ##[0:1] busy_o)
    else $error("ack left block idle");
  rdata_quiet_a: assert property (!$past(bus_i.rd) |-> bus_rdata_o == 32'h0)
    else $error("read data without read");
  ready_no_card_a: assert property (dcmd_ready_o |-> !ccmd_o.req ##1 !ccmd_o.req)
    else $error("card command on continuation");
  ready_pulse_a: assert property ($rose(dcmd_ready_o) |=> !dcmd_ready_o)
    else $error("ready too long");
  err_report_a: assert property (ccmd_done_i && ccmd_err_i |-> ##[1:2] dcmd_err_o)
    else $error("response error not reported");
  err_no_dma_a: assert property (dcmd_err_o |-> !dma_start_o [*2])
    else $error("dma after error");
  req_pulse_a: assert property (ccmd_o.req |=> !ccmd_o.req)
    else $error("command request too long");
  freeze_busy_a: assert property ($rose(clk_freeze_o) |-> busy_o)
    else $error("freeze while idle");
  // main scenarios
  cv_ready: cover property (dcmd_ready_o);
  cv_err: cover property (dcmd_err_o);
  cv_freeze: cover property ($rose(clk_freeze_o));
endmodule
bind sdq_sequencer sdq_sequencer_asserts sdq_sequencer_asserts_i (.*);
`default_nettype wire

// *** test/sdq_card_model.sv ***
// Purpose: card and data mover stand-in
// Assumes: one answer per card command
// Notes: error flag meaningful only beside done
`timescale 1ns/100ps
`default_nettype none
module sdq_card_model
  import sdq_pkg::*;
(
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  // command side
  input wire sdq_ccmd_s ccmd_i,
  input wire logic err_en_i,
  output logic done_o,
  output logic err_o,
  // data side
  input wire logic start_i,
  input wire logic [15:0] nbytes_i,
  output logic byte_o,
  output logic dma_done_o
);
  int cw;
  int bc;
  // answer after 1..4 cycles, bytes with random stalls
  always @(posedge sys_clk_i or posedge sys_rst_i) begin
    done_o <= 1'b0;
    err_o <= 1'($urandom);
    byte_o <= 1'b0;
    dma_done_o <= 1'b0;
    if (sys_rst_i) begin
      cw <= 0;
      bc <= 0;
    end else begin
      cw <= ccmd_i.req ? 1 + $urandom_range(3) : (cw > 0 ? cw - 1 : 0);
      if (cw == 1 && !ccmd_i.req) begin
        done_o <= 1'b1;
        err_o <= err_en_i;
      end
      if (start_i) begin
        bc <= int'(nbytes_i) + 1;
      end else if (bc == 1) begin
        dma_done_o <= 1'b1;
        bc <= 0;
      end else if (bc > 1 && $urandom_range(1) == 1) begin
        byte_o <= 1'b1;
        bc <= bc - 1;
      end
    end
  end
endmodule
`default_nettype wire

// *** test/tb_sdq_sequencer.sv ***
// Purpose: self-checking bench of the transfer sequencer
// Assumes: model answers commands and moves data
// Notes: hold timeout cut to 20 cycles
`timescale 1ns/100ps
`default_nettype none
module tb_sdq_sequencer;
  import sdq_pkg::*;
  logic clk, rst, valid, ack, rdy, derr, cdone, cerr, dstart, dbyte, ddone, frz, busy;
  logic err_en, idle_f, s_frz, s_rdy, s_err, s_dma, s_done;
  logic [15:0] nbytes, rca;
  logic [31:0] rdat, rv, addr, ctrl;
  sdq_bus_s bus;
  sdq_dcmd_s dcmd;
  sdq_ccmd_s ccmd;
  logic [5:0] iq[$];
  logic [31:0] aq[$];
  int n_fail = 0;
  int total_checks = 0;
  sdq_sequencer #(.TMO_CYC(20)) sdq_sequencer_i (.sys_clk_i(clk), .sys_rst_i(rst),
    .bus_i(bus), .bus_rdata_o(rdat), .dcmd_valid_i(valid), .dcmd_i(dcmd), .dcmd_ack_o(ack),
    .dcmd_ready_o(rdy), .dcmd_err_o(derr), .ccmd_o(ccmd), .ccmd_done_i(cdone),
    .ccmd_err_i(cerr), .dma_start_o(dstart), .dma_byte_i(dbyte), .dma_done_i(ddone),
    .clk_freeze_o(frz), .busy_o(busy));
  sdq_card_model sdq_card_model_i (.sys_clk_i(clk), .sys_rst_i(rst), .ccmd_i(ccmd),
    .err_en_i(err_en), .done_o(cdone), .err_o(cerr), .start_i(dstart | rdy),
    .nbytes_i(nbytes), .byte_o(dbyte), .dma_done_o(ddone));
  // clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // record card commands and events
  always @(posedge clk) begin
    idle_f <= (busy === 1'b0);
    if (ccmd.req === 1'b1) begin
      iq.push_back(ccmd.index);
      aq.push_back(ccmd.arg);
    end
    if (frz === 1'b1) s_frz <= 1'b1;
    if (rdy === 1'b1) s_rdy <= 1'b1;
    if (derr === 1'b1) s_err <= 1'b1;
    if (dstart === 1'b1) s_dma <= 1'b1;
    if (ddone === 1'b1) s_done <= 1'b1;
  end
  task automatic report_and_stop();
    $display("checks %0d failures %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("Error %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk_seq(input logic [5:0] ei[$], input logic [31:0] ea[$]);
    chk(32'(iq.size()), 32'(ei.size()));
    foreach (ei[i]) chk({26'h0, iq[i]}, {26'h0, ei[i]});
    foreach (ea[i]) chk(aq[i], ea[i]);
  endtask
  task automatic wait_for(ref logic f, input int lim);
    int k;
    repeat (2) @(posedge clk);
    for (k = 0; k < lim && f !== 1'b1; k++) @(posedge clk);
    if (k == lim) begin
      n_fail++;
      $display("Error %0t wait ran out", $time);
      report_and_stop();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus <= '{a, d, 1'b1, 1'b0};
    @(posedge clk);
    bus <= '0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] a);
    bus <= '{a, 32'h0, 1'b0, 1'b1};
    @(posedge clk);
    bus <= '0;
    @(posedge clk);
    rv = rdat;
  endtask
  task automatic send(input sdq_dcmd_e c, input logic [31:0] a, input logic [15:0] n);
    iq.delete();
    aq.delete();
    {s_frz, s_rdy, s_err, s_dma, s_done} <= 5'h0;
    dcmd <= '{a, n, 3'h1, c, 2'h0, 4'h3};
    nbytes <= (c >= DC_MAN_READ) ? n : {n[6:0], 9'h000};
    valid <= 1'b1;
    wait_for(ack, 50);
    valid <= 1'b0;
  endtask
  // expected card address
  function automatic logic [31:0] cvt(input logic [31:0] a, input logic [31:0] c);
    return (c[10:8] == OPT_LBA || c[CTRL_LARGE]) ? a : a << BLK_SHIFT;
  endfunction
  // main sequence
  initial begin
    {rst, valid, err_en, bus, dcmd, nbytes} = '0;
    rst = 1'b1;
    void'($urandom(32'h63dd5524));
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    for (int i = 0; i < 3; i++) begin
      rd(i == 0 ? REG_CTRL : i == 1 ? REG_RCA : 8'h40);
      chk(rv, 32'h0);
    end
    rca = 16'($urandom);
    wr(REG_RCA, {16'h0, rca});
    for (int m = 0; m < 4; m++) begin
      ctrl = m == 1 ? 32'h400 : m == 2 ? 32'h10 : m == 3 ? 32'h4 : 32'h0;
      wr(REG_CTRL, ctrl);
      addr = $urandom & 32'h003FFFFF;
      send(DC_NEW_READ, addr, 16'h1);
      wait_for(idle_f, 4000);
      if (m < 3) chk({31'h0, s_frz}, 32'h1);
      chk_seq('{m == 3 ? CIDX_RD_STREAM : CIDX_RD_MULTI, CIDX_STOP}, '{cvt(addr, ctrl)});
    end
    // held read, then a fresh read closes it; timeout ends the second
    wr(REG_CTRL, 32'h1);
    send(DC_NEW_READ, addr, 16'h1);
    wait_for(s_done, 4000);
    chk_seq('{CIDX_RD_MULTI}, '{addr << 9});
    addr = $urandom & 32'h003FFFFF;
    send(DC_NEW_READ, addr, 16'h1);
    wait_for(idle_f, 4000);
    chk_seq('{CIDX_STOP, CIDX_RD_MULTI, CIDX_STOP}, '{32'h0, addr << 9});
    // continuous stream ignores the data end and waits for a command
    wr(REG_CTRL, 32'hC);
    send(DC_NEW_READ, addr, 16'h1);
    wait_for(s_done, 4000);
    chk({31'h0, busy}, 32'h1);
    chk_seq('{CIDX_RD_STREAM}, '{addr << 9});
    wr(REG_CTRL, 32'h8);
    send(DC_NEW_READ, addr, 16'h1);
    wait_for(idle_f, 4000);
    chk_seq('{CIDX_STOP, CIDX_RD_MULTI, CIDX_STOP}, '{32'h0, addr << 9});
    wr(REG_CTRL, 32'h0);
    send(DC_NEW_WRITE, addr, 16'h2);
    wait_for(idle_f, 6000);
    chk_seq('{CIDX_APP, CIDX_PRE_ERASE, CIDX_WR_MULTI, CIDX_STOP},
      '{{rca, 16'h0}, 32'h2, addr << 9});
    wr(REG_CTRL, 32'h2);
    send(DC_NEW_WRITE, addr, 16'h1);
    wait_for(s_done, 4000);
    chk_seq('{CIDX_APP, CIDX_WR_MULTI}, '{{rca, 16'h0}, addr << 9});
    send(DC_CONT_WRITE, addr, 16'h1);
    wait_for(idle_f, 4000);
    chk({31'h0, s_rdy}, 32'h1);
    chk_seq('{CIDX_STOP}, '{});
    wr(REG_CTRL, 32'h0);
    err_en <= 1'b1;
    send(DC_NEW_READ, addr, 16'h1);
    wait_for(idle_f, 400);
    chk({30'h0, s_err, s_dma}, 32'h2);
    err_en <= 1'b0;
    rd(REG_STATUS);
    chk(rv, 32'h1 << STAT_ERR);
    wr(REG_STATUS, 32'h1 << STAT_ERR);
    rd(REG_STATUS);
    chk(rv, 32'h0);
    for (int m = 0; m < 2; m++) begin
      send(m == 1 ? DC_MAN_WRITE : DC_MAN_READ, addr, 16'(16 + $urandom_range(48)));
      wait_for(idle_f, 400);
      chk({31'h0, s_dma}, 32'h1);
      chk_seq('{}, '{});
    end
    report_and_stop();
  end
endmodule
`default_nettype wire
